// >>> src/i2c_init_pkg.sv
// Purpose: shared constants and types for the two-wire module with forced init
// Assumes: 25 MHz module clock, Avalon-MM register bus, open-drain SCL/SDA
// Notes:   every register is one aligned 32-bit word, data in bits 7:0
//
// What this block does
// - writing an init code to the switch register, or clearing enable, starts init
// - init resets the internal transmit-empty and receive-full flags
// - init returns the sequencer to idle and clears the operating clock counter
// - init resets the SCL/SDA output latches, wait state included
// - init leaves every software-written register value unchanged
// - init keeps the latches that remember reads made before flag clears
// - init keeps the bit count field of the mode register
// - init keeps interrupt flags set and requests already passed on
// - the clear command field is never stored; it reads back as zero
// - init during a transfer aborts it at once and releases both pins
// - slave address shares the mode offset, reachable only while disabled
package i2c_init_pkg;

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam int          ADDR_W     = 5;
	localparam logic [4:0]  OFF_DATA   = 5'h00;
	localparam logic [4:0]  OFF_MODE   = 5'h04;
	localparam logic [4:0]  OFF_SADR2  = 5'h08;
	localparam logic [4:0]  OFF_CTRL   = 5'h0C;
	localparam logic [4:0]  OFF_STAT   = 5'h10;
	localparam logic [4:0]  OFF_SWITCH = 5'h14;
	localparam logic [4:0]  OFF_TIMER  = 5'h18;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_EN_BIT     = 7;
	localparam int CTRL_IE_BIT     = 6;
	localparam int CTRL_TX_BIT     = 4;
	localparam int CTRL_ACKOUT_BIT = 2;
	localparam int CTRL_START_BIT  = 1;
	localparam int CTRL_STOP_BIT   = 0;
	localparam int STAT_TDE_BIT    = 7;
	localparam int STAT_RDF_BIT    = 6;
	localparam int STAT_IRQ_BIT    = 5;
	localparam int STAT_ACK_BIT    = 4;
	localparam int STAT_BUSY_BIT   = 3;
	localparam int STAT_WAIT_BIT   = 2;
	localparam int CLR_INIT_BIT    = 3;
	localparam int BC_MSB          = 2;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic       TDE_RST = 1'b1;
	localparam logic       RDF_RST = 1'b0;
	localparam logic [3:0] CLR_READ_VAL = 4'h0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int         CLK_PERIOD_NS = 40;
	localparam int         T_HALF_NS     = 160;
	localparam logic [7:0] HALF_CYC      = 8'((T_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic scl;
		logic sda;
	} pins_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              rd;
		logic              wr;
		logic [7:0]        wdata;
	} bus_req_t;

	typedef enum logic [3:0] {
		SEQ_IDLE,
		SEQ_START_A,
		SEQ_START_B,
		SEQ_HOLD,
		SEQ_BIT_LOW,
		SEQ_BIT_HIGH,
		SEQ_ACK_LOW,
		SEQ_ACK_HIGH,
		SEQ_STOP_A,
		SEQ_STOP_B,
		SEQ_STOP_C
	} seq_state_t;

endpackage : i2c_init_pkg

// >>> src/pin_sync.sv
// Purpose: two-flop synchroniser for the sampled SCL and SDA pin levels
// Assumes: pins are asynchronous to i_clk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync
	import i2c_init_pkg::*;
(
	// clock and reset
	input  wire logic  i_clk,
	input  wire logic  i_arst_n,
	// pin levels
	input  wire pins_t i_pins,
	output pins_t      o_pins
);

	pins_t meta_reg;
	pins_t sync_reg;

	// two stages, released pins read as high
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			meta_reg <= 2'h3;
			sync_reg <= 2'h3;
		end
		else
		begin
			meta_reg <= i_pins;
			sync_reg <= meta_reg;
		end
	end

	assign o_pins = sync_reg;

endmodule : pin_sync

// >>> src/i2c_forced_state_init.sv
// Purpose: two-wire master byte engine with forced internal-state init
// Assumes: Avalon-MM slave with waitrequest, open-drain SCL/SDA pins
// Notes:   init touches only flags, sequencer, counter and pin latches
//
// The Avalon-MM slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module i2c_forced_state_init
	import i2c_init_pkg::*;
(
	// clock and reset
	input  wire logic              i_clk,
	input  wire logic              i_arst_n,
	// avalon-mm register slave
	input  wire logic [ADDR_W-1:0] i_avs_address,
	input  wire logic              i_avs_read,
	input  wire logic              i_avs_write,
	input  wire logic [31:0]       i_avs_writedata,
	output logic      [31:0]       o_avs_readdata,
	output logic                   o_avs_waitrequest,
	// two-wire pins
	input  wire logic              i_scl,
	input  wire logic              i_sda,
	output logic                   o_scl,
	output logic                   o_scl_oe_n,
	output logic                   o_sda,
	output logic                   o_sda_oe_n,
	// interrupt request level
	output logic                   o_irq
);

	// ----------------------------------------------------------------
	// helper functions
	// ----------------------------------------------------------------

	// half period in module clocks, scaled by the timer register nibble
	function automatic logic [7:0] half_limit(input logic [3:0] scale);
		logic [7:0] mult;
		mult = {4'h0, scale} + 8'h01;
		return 8'(mult * HALF_CYC);
	endfunction : half_limit

	// states in which SCL is released and may be stretched
	function automatic logic phase_high(input seq_state_t st);
		return (st == SEQ_BIT_HIGH) || (st == SEQ_ACK_HIGH);
	endfunction : phase_high

	// states that hold SCL low
	function automatic logic drives_scl(input seq_state_t st);
		return (st == SEQ_START_B) || (st == SEQ_HOLD) || (st == SEQ_BIT_LOW)
			|| (st == SEQ_ACK_LOW) || (st == SEQ_STOP_A);
	endfunction : drives_scl

	// wanted SDA drive for a state
	function automatic logic sda_want(input seq_state_t st, input logic tx, input logic bit7,
		input logic ackout);
		logic want;
		want = 1'b0;
		unique case (st)
			SEQ_START_A, SEQ_START_B, SEQ_STOP_A, SEQ_STOP_B: want = 1'b1;
			SEQ_BIT_LOW:                                      want = tx & ~bit7;
			SEQ_ACK_LOW:                                      want = ~tx & ~ackout;
			default:                                          want = 1'b0;
		endcase
		return want;
	endfunction : sda_want

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	bus_req_t   req;
	pins_t      pins_s;
	logic       ack_reg;
	logic       wr_go;
	logic       rd_go;
	logic       rd_done;
	logic       sel_data;
	logic       sel_mode;
	logic       sel_sadr2;
	logic       sel_ctrl;
	logic       sel_stat;
	logic       sel_switch;
	logic       sel_timer;
	logic       init_pulse;
	logic       start_pulse;
	logic [7:0] tx_data_reg;
	logic [7:0] rx_data_reg;
	logic [7:0] sadr_reg;
	logic [7:0] sadr2_reg;
	logic [7:0] mode_reg;
	logic [7:0] ctrl_reg;
	logic [3:0] switch_hi_reg;
	logic [7:0] timer_reg;
	logic       tx_empty_reg;
	logic       rx_full_reg;
	logic       irq_flag_reg;
	logic       irq_seen_reg;
	logic       ack_rx_reg;
	logic       stop_req_reg;
	logic       irq_out_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	seq_state_t state_reg;
	seq_state_t state_next;
	logic [7:0] cnt_reg;
	logic [7:0] shift_reg;
	logic       stalled;
	logic       tick;
	logic       load_tx;
	logic       rx_go;
	logic [2:0] bc_dec;
	logic       byte_done;
	logic       scl_drv_reg;
	logic       sda_drv_reg;
	logic       wait_reg;
	logic       enabled;
	logic       tx_mode;

	// ----------------------------------------------------------------
	// pin input synchroniser
	// ----------------------------------------------------------------
	pin_sync u_pin_sync (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_pins   ({i_scl, i_sda}),
		.o_pins   (pins_s)
	);

	// ----------------------------------------------------------------
	// avalon-mm slave: one wait cycle, then answer
	// ----------------------------------------------------------------
	assign req = {i_avs_address, i_avs_read, i_avs_write, i_avs_writedata[7:0]};

	// acknowledge the cycle after the request appears
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			ack_reg <= 1'b0;
		else
			ack_reg <= (req.rd | req.wr) & ~ack_reg;
	end

	assign o_avs_waitrequest = (req.rd | req.wr) & ~ack_reg;
	assign wr_go             = req.wr & ack_reg;
	assign rd_go             = req.rd & ~ack_reg;
	assign rd_done           = req.rd & ack_reg;

	// address decode
	assign sel_data   = (req.addr == OFF_DATA);
	assign sel_mode   = (req.addr == OFF_MODE);
	assign sel_sadr2  = (req.addr == OFF_SADR2);
	assign sel_ctrl   = (req.addr == OFF_CTRL);
	assign sel_stat   = (req.addr == OFF_STAT);
	assign sel_switch = (req.addr == OFF_SWITCH);
	assign sel_timer  = (req.addr == OFF_TIMER);
	assign enabled    = ctrl_reg[CTRL_EN_BIT];
	assign tx_mode    = ctrl_reg[CTRL_TX_BIT];

	// init trigger: init code in the clear field, or enable written to zero
	assign init_pulse = (wr_go & sel_switch & req.wdata[CLR_INIT_BIT])
		| (wr_go & sel_ctrl & ~req.wdata[CTRL_EN_BIT]);
	assign start_pulse = wr_go & sel_ctrl & req.wdata[CTRL_EN_BIT] & req.wdata[CTRL_START_BIT];

	// read mux, unmapped offsets read zero
	always_comb
	begin
		rdata_next = 8'h00;
		unique case (1'b1)
			sel_data:   rdata_next = rx_data_reg;
			sel_mode:   rdata_next = enabled ? mode_reg : sadr_reg;
			sel_sadr2:  rdata_next = sadr2_reg;
			sel_ctrl:   rdata_next = {ctrl_reg[7:2], 2'b00};
			sel_stat:   rdata_next = {tx_empty_reg, rx_full_reg, irq_flag_reg, ack_rx_reg,
				(state_reg != SEQ_IDLE), wait_reg, 2'b00};
			sel_switch: rdata_next = {switch_hi_reg, CLR_READ_VAL};
			sel_timer:  rdata_next = timer_reg;
			default:    rdata_next = 8'h00;
		endcase
	end

	// read data register, loaded while waitrequest is high
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			rdata_reg <= 8'h00;
		else if (rd_go)
			rdata_reg <= rdata_next;
	end

	assign o_avs_readdata = {24'h000000, rdata_reg};

	// ----------------------------------------------------------------
	// software registers, untouched by init
	// ----------------------------------------------------------------

	// plain stored registers
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			tx_data_reg   <= REG_RST;
			sadr_reg      <= REG_RST;
			sadr2_reg     <= REG_RST;
			ctrl_reg      <= REG_RST;
			switch_hi_reg <= 4'h0;
			timer_reg     <= REG_RST;
		end
		else
		begin
			if (wr_go & sel_data)
				tx_data_reg <= req.wdata;
			if (wr_go & sel_mode & ~enabled)
				sadr_reg <= req.wdata;
			if (wr_go & sel_sadr2)
				sadr2_reg <= req.wdata;
			if (wr_go & sel_ctrl)
				ctrl_reg <= {req.wdata[7:2], 2'b00};
			if (wr_go & sel_switch)
				switch_hi_reg <= req.wdata[7:4];
			if (wr_go & sel_timer)
				timer_reg <= req.wdata;
		end
	end

	// mode register; bit count decremented by the sequencer, kept by init
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			mode_reg <= REG_RST;
		else if (tick && (state_reg == SEQ_BIT_HIGH) && !init_pulse)
			mode_reg[BC_MSB:0] <= bc_dec;
		else if (wr_go & sel_mode & enabled)
			mode_reg <= req.wdata;
	end

	// interrupt flag: read-as-one then write-zero clears; set wins
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			irq_flag_reg <= 1'b0;
			irq_seen_reg <= 1'b0;
		end
		else
		begin
			if (byte_done)
				irq_flag_reg <= 1'b1;
			else if (wr_go & sel_stat & irq_seen_reg & ~req.wdata[STAT_IRQ_BIT])
				irq_flag_reg <= 1'b0;
			if (rd_done & sel_stat & rdata_reg[STAT_IRQ_BIT])
				irq_seen_reg <= 1'b1;
			else if (wr_go & sel_stat)
				irq_seen_reg <= 1'b0;
		end
	end

	// interrupt output level, never withdrawn by init
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			irq_out_reg <= 1'b0;
		else
			irq_out_reg <= irq_flag_reg & ctrl_reg[CTRL_IE_BIT];
	end

	assign o_irq = irq_out_reg;

	// received data and acknowledge status
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			rx_data_reg <= REG_RST;
			ack_rx_reg  <= 1'b0;
		end
		else if (byte_done)
		begin
			ack_rx_reg <= ~pins_s.sda;
			if (!tx_mode)
				rx_data_reg <= shift_reg;
		end
	end

	// ----------------------------------------------------------------
	// internal data flags, reset by init
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			tx_empty_reg <= TDE_RST;
			rx_full_reg  <= RDF_RST;
		end
		else if (init_pulse)
		begin
			tx_empty_reg <= TDE_RST;
			rx_full_reg  <= RDF_RST;
		end
		else
		begin
			if (load_tx)
				tx_empty_reg <= 1'b1;
			else if (wr_go & sel_data)
				tx_empty_reg <= 1'b0;
			if (byte_done & ~tx_mode)
				rx_full_reg <= 1'b1;
			else if (rd_done & sel_data)
				rx_full_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	assign stalled   = phase_high(state_reg) & ~pins_s.scl;
	assign tick      = (state_reg != SEQ_IDLE) && (state_reg != SEQ_HOLD) && !stalled
		&& (cnt_reg == half_limit(timer_reg[3:0]) - 8'h01);
	assign bc_dec    = mode_reg[BC_MSB:0] - 3'h1;
	assign byte_done = tick && (state_reg == SEQ_ACK_HIGH) && !init_pulse;
	// a data write in the same cycle holds off the load so no byte is lost
	assign load_tx   = (state_reg == SEQ_HOLD) && !stop_req_reg && tx_mode && !tx_empty_reg
		&& !(wr_go & sel_data) && !init_pulse;
	assign rx_go     = (state_reg == SEQ_HOLD) && !stop_req_reg && !tx_mode && !rx_full_reg;

	// next state; init forces idle from any state
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			SEQ_IDLE:     if (start_pulse) state_next = SEQ_START_A;
			SEQ_START_A:  if (tick) state_next = SEQ_START_B;
			SEQ_START_B:  if (tick) state_next = SEQ_HOLD;
			SEQ_HOLD:
			begin
				if (stop_req_reg)
					state_next = SEQ_STOP_A;
				else if (load_tx || rx_go)
					state_next = SEQ_BIT_LOW;
			end
			SEQ_BIT_LOW:  if (tick) state_next = SEQ_BIT_HIGH;
			SEQ_BIT_HIGH: if (tick) state_next = (bc_dec == 3'h0) ? SEQ_ACK_LOW : SEQ_BIT_LOW;
			SEQ_ACK_LOW:  if (tick) state_next = SEQ_ACK_HIGH;
			SEQ_ACK_HIGH: if (tick) state_next = SEQ_HOLD;
			SEQ_STOP_A:   if (tick) state_next = SEQ_STOP_B;
			SEQ_STOP_B:   if (tick) state_next = SEQ_STOP_C;
			SEQ_STOP_C:   if (tick) state_next = SEQ_IDLE;
			default:      state_next = SEQ_IDLE;
		endcase
		if (init_pulse)
			state_next = SEQ_IDLE;
	end

	// state register
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			state_reg <= SEQ_IDLE;
		else
			state_reg <= state_next;
	end

	// stop request, latched until the stop condition completes or init clears it
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			stop_req_reg <= 1'b0;
		else if (init_pulse || (tick && state_reg == SEQ_STOP_C))
			stop_req_reg <= 1'b0;
		else if (wr_go & sel_ctrl & req.wdata[CTRL_EN_BIT] & req.wdata[CTRL_STOP_BIT])
			stop_req_reg <= 1'b1;
	end

	// operating clock counter, frozen while a slave stretches SCL
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			cnt_reg <= 8'h00;
		else if (init_pulse || tick || state_reg == SEQ_IDLE || state_reg == SEQ_HOLD)
			cnt_reg <= 8'h00;
		else if (!stalled)
			cnt_reg <= cnt_reg + 8'h01;
	end

	// shift register: load for transmit, sample SDA on each data bit high phase
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			shift_reg <= 8'h00;
		else if (load_tx)
			shift_reg <= tx_data_reg;
		else if (tick && state_reg == SEQ_BIT_HIGH)
			shift_reg <= {shift_reg[6:0], pins_s.sda};
	end

	// ----------------------------------------------------------------
	// pin output latches
	// ----------------------------------------------------------------

	// SCL drive and wait latch; init releases at once
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			scl_drv_reg <= 1'b0;
			wait_reg    <= 1'b0;
		end
		else if (init_pulse)
		begin
			scl_drv_reg <= 1'b0;
			wait_reg    <= 1'b0;
		end
		else
		begin
			scl_drv_reg <= drives_scl(state_reg);
			wait_reg    <= stalled;
		end
	end

	// SDA drive; data bits change only once SCL is already held low
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			sda_drv_reg <= 1'b0;
		else if (init_pulse)
			sda_drv_reg <= 1'b0;
		else if (state_reg == SEQ_BIT_LOW || state_reg == SEQ_ACK_LOW)
		begin
			if (scl_drv_reg)
				sda_drv_reg <= sda_want(state_reg, tx_mode, shift_reg[7], ctrl_reg[CTRL_ACKOUT_BIT]);
		end
		else if (!(phase_high(state_reg) || state_reg == SEQ_HOLD))
			sda_drv_reg <= sda_want(state_reg, tx_mode, shift_reg[7], ctrl_reg[CTRL_ACKOUT_BIT]);
	end

	// open drain: output value low, enable active low while driving
	assign o_scl      = 1'b0;
	assign o_sda      = 1'b0;
	assign o_scl_oe_n = ~scl_drv_reg;
	assign o_sda_oe_n = ~sda_drv_reg;

endmodule : i2c_forced_state_init

// >>> sim/i2c_forced_state_init_props.sv
// Purpose: port checks for the forced-init two-wire block
// Assumes: one clock domain, async low reset
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module i2c_init_props
	import i2c_init_pkg::*;
(
	// clock and reset
	input wire logic              i_clk,
	input wire logic              i_arst_n,
	// register bus
	input wire logic [ADDR_W-1:0] i_avs_address,
	input wire logic              i_avs_read,
	input wire logic              i_avs_write,
	input wire logic [31:0]       i_avs_writedata,
	input wire logic [31:0]       o_avs_readdata,
	input wire logic              o_avs_waitrequest,
	// pins and interrupt
	input wire logic              o_scl,
	input wire logic              o_scl_oe_n,
	input wire logic              o_sda,
	input wire logic              o_sda_oe_n,
	input wire logic              o_irq
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);
	// ----------------
	// bus completions and init triggers
	// ----------------
	sequence s_rd; i_avs_read && !o_avs_waitrequest; endsequence
	sequence s_wr; i_avs_write && !o_avs_waitrequest; endsequence
	sequence s_init_sw; s_wr ##0 (i_avs_address == OFF_SWITCH && i_avs_writedata[CLR_INIT_BIT]); endsequence
	sequence s_init_en; s_wr ##0 (i_avs_address == OFF_CTRL && !i_avs_writedata[CTRL_EN_BIT]); endsequence
	sequence s_freed; ##2 (o_scl_oe_n && o_sda_oe_n); endsequence
	// ----------------
	// properties
	// ----------------
	property p_wait_first; $rose(i_avs_read || i_avs_write) |-> o_avs_waitrequest; endproperty
	a_wait_first: assert property (p_wait_first)
		else $error("new request not held off");
	property p_one_wait; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
	a_one_wait: assert property (p_one_wait)
		else $error("request not answered after one wait");
	property p_sw_zero; s_rd ##0 (i_avs_address == OFF_SWITCH) |-> o_avs_readdata[3:0] == CLR_READ_VAL; endproperty
	a_sw_zero: assert property (p_sw_zero)
		else $error("clear field read back nonzero");
	property p_rd_upper; s_rd |-> o_avs_readdata[31:8] == 24'h000000; endproperty
	a_rd_upper: assert property (p_rd_upper)
		else $error("upper read bits set");
	property p_sw_free; s_init_sw |-> s_freed; endproperty
	a_sw_free: assert property (p_sw_free)
		else $error("pins held after clear command");
	property p_en_free; s_init_en |-> s_freed; endproperty
	a_en_free: assert property (p_en_free)
		else $error("pins held after enable cleared");
	property p_irq_kept; s_init_sw |=> $stable(o_irq) [*2]; endproperty
	a_irq_kept: assert property (p_irq_kept)
		else $error("irq changed by init");
	property p_od_low; o_scl == 1'b0 && o_sda == 1'b0; endproperty
	a_od_low: assert property (p_od_low)
		else $error("pin drive value not low");
endmodule : i2c_init_props

// >>> sim/i2c_bus_partner.sv
// Purpose: bus neighbour that acks bytes and may stretch the clock
// Assumes: wired-and lines with pull-ups, resolved in the bench
// Notes:   ack slot found by counting clock falls since a start
`timescale 1ns/1ps
module i2c_bus_partner
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_arst_n,
	// line levels and stretch request
	input  wire logic i_scl,
	input  wire logic i_sda,
	input  wire logic i_stretch,
	output logic      o_scl_oe_n,
	output logic      o_sda_oe_n
);
	logic scl_q;
	logic sda_q;
	int   falls;
	int   hold;
	// start detect, fall count, ack in the ninth slot
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			scl_q      <= 1'b1;
			sda_q      <= 1'b1;
			falls      <= 0;
			o_sda_oe_n <= 1'b1;
		end
		else
		begin
			scl_q <= i_scl;
			sda_q <= i_sda;
			if (scl_q && i_scl && sda_q && !i_sda)
				falls <= -1;
			else if (scl_q && !i_scl)
			begin
				falls      <= falls + 1;
				o_sda_oe_n <= (falls % 9) != 7;
			end
		end
	end
	// hold the clock low a while after each fall
	always_ff @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			hold <= 0;
		else if (i_stretch && scl_q && !i_scl)
			hold <= 12;
		else if (hold != 0)
			hold <= hold - 1;
	end
	assign o_scl_oe_n = (hold == 0);
endmodule : i2c_bus_partner

// >>> sim/i2c_forced_state_init_test.sv
// Purpose: self-checking bench for the forced-init two-wire block
// Assumes: 25 MHz clock, partner on the lines
// Notes:   mdl holds the expected register words
`timescale 1ns/1ps
module i2c_forced_state_init_test
	import i2c_init_pkg::*;
;
	logic              i_clk;
	logic              i_arst_n;
	logic [ADDR_W-1:0] addr;
	logic              rd;
	logic              wr;
	logic [31:0]       wdata;
	logic [31:0]       rdata;
	logic              wait_req;
	logic              scl_oe_n;
	logic              sda_oe_n;
	logic              p_scl_oe_n;
	logic              p_sda_oe_n;
	logic              stretch;
	logic              irq;
	logic [15:0]       lfsr = 16'hCAE5;
	int                mdl [8];
	int                wk [4] = '{5, 0, 1, 2};
	int                checks = 0;
	int                error_cnt = 0;
	wire               scl_w = scl_oe_n & p_scl_oe_n;
	wire               sda_w = sda_oe_n & p_sda_oe_n;
	// clock
	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	// design and bus neighbour
	i2c_forced_state_init dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_req),
		.i_scl(scl_w), .i_sda(sda_w), .o_scl(), .o_scl_oe_n(scl_oe_n), .o_sda(), .o_sda_oe_n(sda_oe_n), .o_irq(irq));
	i2c_bus_partner u_partner (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_scl(scl_w), .i_sda(sda_w),
		.i_stretch(stretch), .o_scl_oe_n(p_scl_oe_n), .o_sda_oe_n(p_sda_oe_n));
	// ----------------
	// helpers
	// ----------------
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction : rnd
	task automatic print_verdict();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : print_verdict
	task automatic hang();
		error_cnt++;
		$display("ERROR %0t: wait ran out", $time);
		print_verdict();
	endtask : hang
	task automatic chk(input logic [7:0] got, input logic [7:0] e);
		checks++;
		if (got !== e)
		begin
			error_cnt++;
			$display("ERROR %0t: got %h exp %h", $time, got, e);
		end
	endtask : chk
	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [7:0] q);
		int n;
		n = 0;
		@(posedge i_clk);
		addr  <= a;
		rd    <= !w;
		wr    <= w;
		wdata <= {24'h000000, d};
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (wait_req !== 1'b0 && n < 20);
		q = rdata[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 20)
			hang();
	endtask : bus
	task automatic wreg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		logic [7:0] q;
		bus(1'b1, a, d, q);
	endtask : wreg
	task automatic rdm(input logic [ADDR_W-1:0] a, input int e, input logic [7:0] m);
		logic [7:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q & m, 8'(e) & m);
	endtask : rdm
	// ----------------
	// main sequence
	// ----------------
	initial
	begin
		logic [7:0] q;
		logic [7:0] hi;
		logic [7:0] c;
		i_arst_n = 1'b0;
		addr     = '0;
		rd       = 1'b0;
		wr       = 1'b0;
		wdata    = '0;
		stretch  = 1'b0;
		mdl      = '{default: 0};
		mdl[4]   = 8'h80;
		repeat (2) @(posedge i_clk);
		i_arst_n <= 1'b1;
		// reset words, unmapped offset included
		for (int k = 0; k < 8; k++)
			rdm(ADDR_W'(k * 4), mdl[k], 8'hFF);
		// random storage, then an init that leaves it alone
		foreach (wk[i])
		begin
			q = rnd();
			wreg(ADDR_W'(wk[i] * 4), q);
			// data offset reads the receive side, still empty here
			mdl[wk[i]] = (wk[i] == 5) ? (q & 8'hF0) : (wk[i] == 0) ? 0 : q;
		end
		rdm(OFF_STAT, 8'h00, 8'hC0);
		wreg(OFF_SWITCH, 8'(mdl[5]) | 8'h0C);
		for (int k = 0; k < 8; k++)
			rdm(ADDR_W'(k * 4), mdl[k], 8'hFF);
		// bit count kept; mode offset swaps with enable
		wreg(OFF_CTRL, 8'h80);
		wreg(OFF_MODE, 8'h05);
		rdm(OFF_MODE, 5, 8'h07);
		wreg(OFF_SWITCH, 8'h08);
		rdm(OFF_MODE, 5, 8'h07);
		wreg(OFF_MODE, 8'h00);
		wreg(OFF_CTRL, 8'h00);
		rdm(OFF_MODE, mdl[1], 8'hFF);
		// finished byte raises irq; init keeps it
		wreg(OFF_CTRL, 8'hD2);
		wreg(OFF_DATA, rnd());
		q = 8'h00;
		for (int n = 0; n < 500 && q[STAT_IRQ_BIT] !== 1'b1; n++)
			bus(1'b0, OFF_STAT, 8'h00, q);
		if (q[STAT_IRQ_BIT] !== 1'b1)
			hang();
		wreg(OFF_SWITCH, 8'h08);
		repeat (2) @(posedge i_clk);
		chk({7'h00, irq}, 8'h01);
		rdm(OFF_STAT, 8'h20, 8'h20);
		// the clear below leans on the read latch surviving this init
		wreg(OFF_SWITCH, 8'h08);
		wreg(OFF_STAT, 8'h00);
		repeat (2) @(posedge i_clk);
		chk({7'h00, irq}, 8'h00);
		// abort mid-byte by every init code, last by clearing enable
		for (int k = 0; k < 9; k++)
		begin
			stretch <= k[0];
			hi = rnd() & 8'hF0;
			c  = k[1] ? 8'h82 : 8'h92;
			wreg(OFF_CTRL, c);
			wreg(OFF_DATA, rnd());
			repeat (rnd() % 128) @(posedge i_clk);
			wreg(OFF_SWITCH, hi | (rnd() & 8'h07));
			rdm(OFF_STAT, 8'h08, 8'h08);
			if (k < 8)
				wreg(OFF_SWITCH, hi | 8'(8 + k));
			else
				wreg(OFF_CTRL, 8'h10);
			repeat (2) @(posedge i_clk);
			chk({7'h00, scl_oe_n & sda_oe_n}, 8'h01);
			rdm(OFF_STAT, 8'h80, 8'hCC);
			rdm(OFF_CTRL, (k < 8) ? (c & 8'hFC) : 8'h10, 8'hFF);
			rdm(OFF_SWITCH, hi, 8'hFF);
			rdm(OFF_SADR2, mdl[2], 8'hFF);
		end
		// a clean start then stop command brings the sequencer back to idle
		wreg(OFF_CTRL, 8'h92);
		wreg(OFF_CTRL, 8'h91);
		q = 8'hFF;
		for (int n = 0; n < 100 && q[STAT_BUSY_BIT] !== 1'b0; n++)
			bus(1'b0, OFF_STAT, 8'h00, q);
		if (q[STAT_BUSY_BIT] !== 1'b0)
			hang();
		chk({7'h00, scl_oe_n & sda_oe_n}, 8'h01);
		rdm(OFF_STAT, 8'h80, 8'hCC);
		print_verdict();
	end
endmodule : i2c_forced_state_init_test
bind i2c_forced_state_init i2c_init_props u_props (.i_clk, .i_arst_n, .i_avs_address, .i_avs_read,
	.i_avs_write, .i_avs_writedata, .o_avs_readdata, .o_avs_waitrequest, .o_scl, .o_scl_oe_n, .o_sda,
	.o_sda_oe_n, .o_irq);
